//--- hdl/i2cst_slave.sv
/*
 * I2C slave engine: address match (7 and 10 bit), slave transmit with clock
 * stretching, address hold, master acknowledge capture, slave collision.
 * Assumes open-drain pads outside, SCL also fed to link_scl as a clock,
 * and software driving the command strobes as one-cycle pulses on clock.
 */
`timescale 1ns/1ps

// What this block does
// - Matching read address sets read status, loads buffer, acknowledges ninth bit.
// - After read address acknowledge, clear clock_release and hold SCL low.
// - Buffer write also loads shift register; software then sets clock_release.
// - Transmit bits change on SCL falling edges, stable while SCL high.
// - Master acknowledge latched on ninth rising edge into master_ack_status.
// - Master not-acknowledge ends transfer; idle until next Start.
// - On master not-acknowledge, no stretch, but port_irq_flag still set.
// - On master acknowledge, stretch; software loads next byte and releases.
// - port_irq_flag set on ninth falling edge per byte; software clears it.
// - Collision while transmitting, if enabled, sets collision flag and idles.
// - Start sets start_detected; port_irq_flag only if start interrupt enabled.
// - Address hold: after eighth fall of match, clear release, stretch, flag.
// - Address hold: device drives software-chosen ack value on acknowledge bit.
// - Address hold read: after acknowledge clear release again and flag.
// - Buffer load accepted in any state, even before address acknowledge; loading sets buffer_full.
// - 10-bit high byte match as write: update needed, acknowledge, flag, stretch.
// - Own address write releases SCL; low byte match repeats update and flag.
// - Low byte mismatch still flags and needs update; no buffer_full, release untouched.
// - After 10-bit addressing, data bytes flag; optional stretch per byte.
// - 10-bit high byte compared to 11110, own bits 2:1, then direction.
// - While update needed, stretch without clearing release; address write frees.
// - Hold SCL only once sampled low; keep holding until released.
module i2cst_slave
(
	input wire logic clock,
	input wire logic srst,
	input wire logic link_scl,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic scl_oe,
	output logic sda_o,
	output logic sda_oe,
	input wire i2cst_pkg::i2cst_cfg_t cfg,
	input wire i2cst_pkg::i2cst_cmd_t cmd,
	output i2cst_pkg::i2cst_status_t status
);

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	// Sticky flag: a set in the same cycle as a clear wins
	function automatic logic sticky(input logic cur, input logic set, input logic clr);
		sticky = set | (cur & ~clr);
	endfunction

	// ----------------------------------------------------------------
	// Link domain: SDA captured on every SCL rising edge
	// ----------------------------------------------------------------
	logic lrst_s1_r;
	logic lrst_s2_r;
	logic rise_tog_r;
	logic rise_sda_r;

	always_ff @(posedge link_scl)
	begin
		lrst_s1_r <= srst;
		lrst_s2_r <= lrst_s1_r;
	end

	// Data stays put a whole SCL period, far longer than the toggle crossing
	always_ff @(posedge link_scl)
	begin
		if (lrst_s2_r)
		begin
			rise_tog_r <= 1'b0;
			rise_sda_r <= 1'b1;
		end
		else
		begin
			rise_tog_r <= ~rise_tog_r;
			rise_sda_r <= sda_i;
		end
	end

	// ----------------------------------------------------------------
	// System domain synchronisers and bus events
	// ----------------------------------------------------------------
	logic scl_s1_r;
	logic scl_s2_r;
	logic scl_d_r;
	logic sda_s1_r;
	logic sda_s2_r;
	logic sda_d_r;
	logic tog_s1_r;
	logic tog_s2_r;
	logic tog_seen_r;
	logic ev_fall;
	logic ev_rise;
	logic ev_start;
	logic ev_stop;

	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			scl_s1_r <= 1'b1;
			scl_s2_r <= 1'b1;
			scl_d_r <= 1'b1;
			sda_s1_r <= 1'b1;
			sda_s2_r <= 1'b1;
			sda_d_r <= 1'b1;
			tog_s1_r <= 1'b0;
			tog_s2_r <= 1'b0;
			tog_seen_r <= 1'b0;
		end
		else
		begin
			scl_s1_r <= scl_i;
			scl_s2_r <= scl_s1_r;
			scl_d_r <= scl_s2_r;
			sda_s1_r <= sda_i;
			sda_s2_r <= sda_s1_r;
			sda_d_r <= sda_s2_r;
			tog_s1_r <= rise_tog_r;
			tog_s2_r <= tog_s1_r;
			tog_seen_r <= tog_s2_r;
		end
	end

	assign ev_fall = scl_d_r & ~scl_s2_r;
	assign ev_rise = tog_s2_r ^ tog_seen_r;
	assign ev_start = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
	assign ev_stop = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;

	// ----------------------------------------------------------------
	// Byte engine
	// ----------------------------------------------------------------
	i2cst_pkg::i2cst_state_t state_r;
	i2cst_pkg::i2cst_ack_kind_t kind_r;
	logic [3:0] cnt_r;
	logic [7:0] shift_r;
	logic ack_oe_r;
	logic lo_phase_r;
	logic addr10_done_r;
	logic data_ack_r;
	logic irq_set_r;
	logic bcl_set_r;
	logic ckp_clr_r;
	logic ua_set_r;
	logic bf_set_r;
	logic bf_clr_r;
	logic start_set_r;
	logic [7:0] cap_r;
	logic cap_we_r;
	logic rw_r;
	logic dna_r;
	logic ackt_r;
	logic master_ack_status_r;
	logic hi_match;
	logic lo_match;
	logic seven_match;

	// Own upper bits sit at 2:1 of the own address
	assign hi_match = (shift_r[7:3] == i2cst_pkg::ADDR10_PREFIX)
		&& (shift_r[i2cst_pkg::ADDR10_HI_POS:i2cst_pkg::ADDR10_LO_POS]
		== status.own_address[i2cst_pkg::ADDR10_HI_POS:i2cst_pkg::ADDR10_LO_POS])
		&& (!shift_r[i2cst_pkg::RW_POS] || addr10_done_r);
	assign lo_match = (shift_r == status.own_address);
	assign seven_match = (shift_r[7:1] == status.own_address[7:1]);

	always_ff @(posedge clock)
	begin
		irq_set_r <= 1'b0;
		bcl_set_r <= 1'b0;
		ckp_clr_r <= 1'b0;
		ua_set_r <= 1'b0;
		bf_set_r <= 1'b0;
		bf_clr_r <= 1'b0;
		start_set_r <= 1'b0;
		cap_we_r <= 1'b0;
		if (srst)
		begin
			state_r <= i2cst_pkg::ST_IDLE;
			kind_r <= i2cst_pkg::AK_WRITE;
			cnt_r <= i2cst_pkg::CNT_ZERO;
			shift_r <= i2cst_pkg::BYTE_RST;
			ack_oe_r <= 1'b0;
			lo_phase_r <= 1'b0;
			addr10_done_r <= 1'b0;
			data_ack_r <= 1'b0;
			cap_r <= i2cst_pkg::BYTE_RST;
			rw_r <= 1'b0;
			dna_r <= 1'b0;
			ackt_r <= 1'b0;
			master_ack_status_r <= 1'b0;
		end
		else if (ev_stop)
		begin
			state_r <= i2cst_pkg::ST_IDLE;
			ack_oe_r <= 1'b0;
			ackt_r <= 1'b0;
			addr10_done_r <= 1'b0;
			lo_phase_r <= 1'b0;
		end
		else if (ev_start)
		begin
			state_r <= i2cst_pkg::ST_ADDR;
			cnt_r <= i2cst_pkg::CNT_ZERO;
			ack_oe_r <= 1'b0;
			ackt_r <= 1'b0;
			start_set_r <= 1'b1;
			irq_set_r <= cfg.start_irq_enable;
		end
		else if (cmd.buf_wr)
		begin
			shift_r <= cmd.buf_wdata;
		end
		else
		begin
			case (state_r)
				i2cst_pkg::ST_IDLE:
				begin
					ack_oe_r <= 1'b0;
				end
				i2cst_pkg::ST_ADDR, i2cst_pkg::ST_RX:
				begin
					if (ev_rise)
					begin
						shift_r <= {shift_r[6:0], rise_sda_r};
						cnt_r <= cnt_r + 4'h1;
					end
					else if (ev_fall && cnt_r == i2cst_pkg::RISES_PER_BYTE)
					begin
						cnt_r <= i2cst_pkg::CNT_ZERO;
						if (state_r == i2cst_pkg::ST_RX)
						begin
							cap_r <= shift_r;
							cap_we_r <= 1'b1;
							bf_set_r <= 1'b1;
							dna_r <= 1'b1;
							ack_oe_r <= 1'b1;
							state_r <= i2cst_pkg::ST_DACK;
						end
						else if (cfg.ten_bit_mode && lo_phase_r)
						begin
							dna_r <= 1'b0;
							kind_r <= lo_match ? i2cst_pkg::AK_LOW_OK : i2cst_pkg::AK_LOW_BAD;
							cap_r <= shift_r;
							cap_we_r <= lo_match;
							bf_set_r <= lo_match;
							ack_oe_r <= lo_match;
							state_r <= i2cst_pkg::ST_AACK;
						end
						else if (cfg.ten_bit_mode ? hi_match : seven_match)
						begin
							rw_r <= shift_r[i2cst_pkg::RW_POS];
							dna_r <= 1'b0;
							cap_r <= shift_r;
							cap_we_r <= 1'b1;
							bf_set_r <= 1'b1;
							if (shift_r[i2cst_pkg::RW_POS])
								kind_r <= i2cst_pkg::AK_READ;
							else if (cfg.ten_bit_mode)
								kind_r <= i2cst_pkg::AK_HIGH;
							else
								kind_r <= i2cst_pkg::AK_WRITE;
							if (cfg.address_hold_enable)
							begin
								ckp_clr_r <= 1'b1;
								irq_set_r <= 1'b1;
								ackt_r <= 1'b1;
								ack_oe_r <= 1'b0;
							end
							else
							begin
								ack_oe_r <= 1'b1;
							end
							state_r <= i2cst_pkg::ST_AACK;
						end
						else
						begin
							state_r <= i2cst_pkg::ST_IDLE;
						end
					end
				end
				i2cst_pkg::ST_AACK:
				begin
					// Held choice follows ack_value_select every cycle until SCL falls after the acknowledge bit
					if (ackt_r)
						ack_oe_r <= (cfg.ack_value_select == i2cst_pkg::ACK_LEVEL);
					if (ev_fall)
					begin
						ack_oe_r <= 1'b0;
						ackt_r <= 1'b0;
						cnt_r <= i2cst_pkg::CNT_ZERO;
						if (ackt_r && cfg.ack_value_select != i2cst_pkg::ACK_LEVEL)
						begin
							state_r <= i2cst_pkg::ST_IDLE;
						end
						else
						begin
							irq_set_r <= 1'b1;
							case (kind_r)
								i2cst_pkg::AK_READ:
								begin
									ckp_clr_r <= 1'b1;
									state_r <= i2cst_pkg::ST_TX;
								end
								i2cst_pkg::AK_HIGH:
								begin
									ua_set_r <= 1'b1;
									lo_phase_r <= 1'b1;
									state_r <= i2cst_pkg::ST_ADDR;
								end
								i2cst_pkg::AK_LOW_OK:
								begin
									ua_set_r <= 1'b1;
									lo_phase_r <= 1'b0;
									addr10_done_r <= 1'b1;
									state_r <= i2cst_pkg::ST_RX;
								end
								i2cst_pkg::AK_LOW_BAD:
								begin
									ua_set_r <= 1'b1;
									lo_phase_r <= 1'b0;
									state_r <= i2cst_pkg::ST_IDLE;
								end
								default:
								begin
									state_r <= i2cst_pkg::ST_RX;
								end
							endcase
						end
					end
				end
				i2cst_pkg::ST_DACK:
				begin
					if (ev_fall)
					begin
						ack_oe_r <= 1'b0;
						cnt_r <= i2cst_pkg::CNT_ZERO;
						irq_set_r <= 1'b1;
						ckp_clr_r <= cfg.stretch_each_byte_enable;
						state_r <= i2cst_pkg::ST_RX;
					end
				end
				i2cst_pkg::ST_TX:
				begin
					if (ev_rise)
					begin
						cnt_r <= cnt_r + 4'h1;
						// Released a one but the line reads low: lost arbitration
						if (shift_r[7] && !rise_sda_r && cfg.slave_collision_detect_enable)
						begin
							bcl_set_r <= 1'b1;
							state_r <= i2cst_pkg::ST_IDLE;
						end
					end
					else if (ev_fall)
					begin
						if (cnt_r == i2cst_pkg::RISES_PER_BYTE)
						begin
							bf_clr_r <= 1'b1;
							dna_r <= 1'b1;
							state_r <= i2cst_pkg::ST_MACK;
						end
						else
						begin
							shift_r <= {shift_r[6:0], 1'b1};
						end
					end
				end
				i2cst_pkg::ST_MACK:
				begin
					if (ev_rise)
					begin
						master_ack_status_r <= rise_sda_r;
					end
					else if (ev_fall)
					begin
						cnt_r <= i2cst_pkg::CNT_ZERO;
						irq_set_r <= 1'b1;
						if (master_ack_status_r)
						begin
							state_r <= i2cst_pkg::ST_IDLE;
						end
						else
						begin
							ckp_clr_r <= 1'b1;
							state_r <= i2cst_pkg::ST_TX;
						end
					end
				end
				default:
				begin
					state_r <= i2cst_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Software-visible flags
	// ----------------------------------------------------------------
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			status.port_irq_flag <= 1'b0;
			status.collision_irq_flag <= 1'b0;
			status.start_detected <= 1'b0;
			status.address_update_needed <= 1'b0;
		end
		else
		begin
			status.port_irq_flag <= sticky(status.port_irq_flag, irq_set_r,
				cmd.port_irq_clr);
			status.collision_irq_flag <= sticky(status.collision_irq_flag, bcl_set_r,
				cmd.collision_irq_clr);
			status.start_detected <= sticky(status.start_detected, start_set_r,
				ev_stop);
			status.address_update_needed <= sticky(status.address_update_needed, ua_set_r,
				cmd.addr_wr);
		end
	end

	// Hardware clear wins over a coincident software release
	always_ff @(posedge clock)
	begin
		if (srst)
			status.clock_release <= i2cst_pkg::CLOCK_RELEASE_RST;
		else if (ckp_clr_r)
			status.clock_release <= 1'b0;
		else if (cmd.clock_release_set)
			status.clock_release <= 1'b1;
	end

	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			status.transfer_buffer <= i2cst_pkg::BYTE_RST;
			status.buffer_full <= 1'b0;
		end
		else
		begin
			if (cmd.buf_wr)
				status.transfer_buffer <= cmd.buf_wdata;
			else if (cap_we_r)
				status.transfer_buffer <= cap_r;
			status.buffer_full <= sticky(status.buffer_full, bf_set_r | cmd.buf_wr,
				bf_clr_r | cmd.buf_rd);
		end
	end

	always_ff @(posedge clock)
	begin
		if (srst)
			status.own_address <= i2cst_pkg::OWN_ADDR_RST;
		else if (cmd.addr_wr)
			status.own_address <= cmd.addr_wdata;
	end

	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			status.read_status <= 1'b0;
			status.data_not_address <= 1'b0;
			status.ack_phase_flag <= 1'b0;
			status.master_ack_status <= 1'b0;
		end
		else
		begin
			status.read_status <= rw_r;
			status.data_not_address <= dna_r;
			status.ack_phase_flag <= ackt_r;
			status.master_ack_status <= master_ack_status_r;
		end
	end

	// ----------------------------------------------------------------
	// Pad drivers
	// ----------------------------------------------------------------
	// Only grab SCL once the master has pulled it low, never cut a high time
	always_ff @(posedge clock)
	begin
		if (srst)
			scl_oe <= 1'b0;
		else if (!status.clock_release || status.address_update_needed)
			scl_oe <= scl_oe | ~scl_s2_r;
		else
			scl_oe <= 1'b0;
	end

	always_ff @(posedge clock)
	begin
		if (srst)
			sda_oe <= 1'b0;
		else if (state_r == i2cst_pkg::ST_TX)
			sda_oe <= ~shift_r[7];
		else
			sda_oe <= ack_oe_r;
	end

	always_ff @(posedge clock)
	begin
		scl_o <= 1'b0;
		sda_o <= 1'b0;
	end

endmodule // i2cst_slave

//--- inc/i2cst_pkg.sv
/*
 * Shared types and constants for the I2C slave transmit engine.
 * Assumes a single system clock domain for software ports and SCL as link clock.
 */
package i2cst_pkg;

	// ----------------------------------------------------------------
	// Bus framing
	// ----------------------------------------------------------------
	localparam int BYTE_BITS = 8;
	localparam logic [3:0] RISES_PER_BYTE = 4'h8;
	localparam logic [3:0] CNT_ZERO = 4'h0;
	localparam logic [4:0] ADDR10_PREFIX = 5'h1e;
	localparam int ADDR10_HI_POS = 2;
	localparam int ADDR10_LO_POS = 1;
	localparam int RW_POS = 0;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] OWN_ADDR_RST = 8'h00;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic CLOCK_RELEASE_RST = 1'b1;
	localparam logic ACK_LEVEL = 1'b0;

	// ----------------------------------------------------------------
	// Engine states, one-hot
	// ----------------------------------------------------------------
	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_ADDR = 7'h02,
		ST_AACK = 7'h04,
		ST_TX = 7'h08,
		ST_MACK = 7'h10,
		ST_RX = 7'h20,
		ST_DACK = 7'h40
	} i2cst_state_t;

	// What the acknowledge phase of an address byte concludes to
	typedef enum logic [4:0] {
		AK_READ = 5'h01,
		AK_HIGH = 5'h02,
		AK_LOW_OK = 5'h04,
		AK_LOW_BAD = 5'h08,
		AK_WRITE = 5'h10
	} i2cst_ack_kind_t;

	// ----------------------------------------------------------------
	// Software-side carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic ten_bit_mode;
		logic address_hold_enable;
		logic stretch_each_byte_enable;
		logic slave_collision_detect_enable;
		logic start_irq_enable;
		logic ack_value_select;
	} i2cst_cfg_t;

	typedef struct packed {
		logic buf_wr;
		logic [7:0] buf_wdata;
		logic buf_rd;
		logic addr_wr;
		logic [7:0] addr_wdata;
		logic clock_release_set;
		logic port_irq_clr;
		logic collision_irq_clr;
	} i2cst_cmd_t;

	typedef struct packed {
		logic port_irq_flag;
		logic collision_irq_flag;
		logic buffer_full;
		logic clock_release;
		logic master_ack_status;
		logic ack_phase_flag;
		logic read_status;
		logic data_not_address;
		logic start_detected;
		logic address_update_needed;
		logic [7:0] transfer_buffer;
		logic [7:0] own_address;
	} i2cst_status_t;

endpackage

//--- tb/i2cst_chk.sv
/*
 * Port checker for the I2C slave engine, bound into every instance.
 * Assumes SCL phases much longer than the engine's synchroniser delay.
 */
`timescale 1ns/1ps
module i2cst_chk
(
	input wire logic clock,
	input wire logic srst,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic scl_oe,
	input wire logic sda_oe,
	input wire i2cst_pkg::i2cst_cmd_t cmd,
	input wire i2cst_pkg::i2cst_status_t status
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);

	AST_WAIT_LOW: assert property ($rose(scl_oe) |-> !$past(scl_i))
		else $error("stretch began while SCL high");
	AST_HOLD_KEPT: assert property ($fell(scl_oe) |->
		status.clock_release && !status.address_update_needed)
		else $error("stretch ended early");
	AST_STRETCH: assert property ($fell(status.clock_release) |-> ##[1:6] scl_oe)
		else $error("no stretch after release cleared");
	AST_IRQ_STICKY: assert property ($fell(status.port_irq_flag) |-> $past(cmd.port_irq_clr))
		else $error("port flag dropped alone");
	AST_COLL_STICKY: assert property ($fell(status.collision_irq_flag) |->
		$past(cmd.collision_irq_clr))
		else $error("collision flag dropped alone");
	AST_BUF_LOAD: assert property (cmd.buf_wr |=>
		status.buffer_full && status.transfer_buffer == $past(cmd.buf_wdata))
		else $error("buffer load lost");
	AST_SDA_STABLE: assert property (scl_i [*5] |-> $stable(sda_oe))
		else $error("data moved while SCL high");
	AST_START_SEEN: assert property ($fell(sda_i) && scl_i && $past(scl_i) |->
		##[1:8] status.start_detected)
		else $error("start not flagged");
	AST_NACK_FREE: assert property ($rose(status.master_ack_status) |-> ##1 (!scl_oe) [*8])
		else $error("stretch after master nack");
	AST_UA_STRETCH: assert property ($rose(status.address_update_needed) |-> ##[0:6] scl_oe)
		else $error("no stretch on address update");

	cover property ($rose(status.master_ack_status));
	cover property ($rose(status.collision_irq_flag));
	cover property ($rose(status.address_update_needed));
endmodule // i2cst_chk

bind i2cst_slave i2cst_chk u_chk (.clock(clock), .srst(srst), .scl_i(scl_i), .sda_i(sda_i),
	.scl_oe(scl_oe), .sda_oe(sda_oe), .cmd(cmd), .status(status));

//--- tb/i2cst_master.sv
/*
 * Bus master model for the I2C slave bench: open-drain SCL and SDA with pull-ups.
 * Assumes the bench calls one task at a time and serves stretches promptly.
 */
`timescale 1ns/1ps
module i2cst_master
(
	input wire logic dev_scl_oe,
	input wire logic dev_sda_oe,
	output wire logic scl,
	output wire logic sda
);
	logic m_scl = 1'b1;
	logic m_sda = 1'b1;
	// Pull-ups: a released line reads high
	assign scl = m_scl & ~dev_scl_oe;
	assign sda = m_sda & ~dev_sda_oe;

	// ------------------------------------------------------------
	// Bit timing on a 64 ns grid
	// ------------------------------------------------------------
	task automatic tick(input int n);
		#(64 * n);
	endtask
	// Bounded wait, so a stuck stretch cannot hang the model
	task automatic up();
		int k;
		m_scl = 1'b1;
		for (k = 0; k < 500 && scl !== 1'b1; k++)
			tick(1);
		tick(5);
	endtask
	task automatic pump(input int n);
		repeat (n)
		begin
			m_scl = 1'b0;
			#32;
			m_scl = 1'b1;
			#32;
		end
	endtask
	task automatic bit_io(input logic b, output logic r);
		m_sda = b;
		tick(5);
		up();
		r = sda;
		tick(5);
		m_scl = 1'b0;
		tick(5);
	endtask
	task automatic start();
		m_sda = 1'b1;
		tick(5);
		up();
		m_sda = 1'b0;
		tick(5);
		m_scl = 1'b0;
		tick(5);
	endtask
	task automatic stop();
		m_sda = 1'b0;
		tick(5);
		up();
		m_sda = 1'b1;
		tick(10);
	endtask
	task automatic wbyte(input logic [7:0] v, output logic nack);
		for (int i = 7; i >= 0; i--)
			bit_io(v[i], nack);
		bit_io(1'b1, nack);
	endtask
	task automatic rbyte(input logic [7:0] drv, input logic nack, output logic [7:0] v);
		logic r;
		for (int i = 7; i >= 0; i--)
		begin
			bit_io(drv[i], r);
			v[i] = r;
		end
		bit_io(nack, r);
	endtask
endmodule // i2cst_master

//--- tb/tb.sv
/*
 * Self-checking bench for the I2C slave engine: 7-bit read, refusal,
 * address hold, collision and 10-bit addressing. Assumes the master model.
 */
`timescale 1ns/1ps
module tb;
	logic clock = 1'b0;
	logic srst = 1'b1;
	logic scl_oe, sda_oe, scl, sda, nk;
	logic [6:0] a7;
	logic [7:0] d, lo, hi;
	logic [7:0] txq[$];
	int miscompares = 0;
	int comparisons = 0;
	int cyc = 0;
	i2cst_pkg::i2cst_cfg_t cfg = '0;
	i2cst_pkg::i2cst_cmd_t cmd = '0;
	i2cst_pkg::i2cst_status_t status;

	always #5 clock = ~clock;

	i2cst_slave u_dut (.clock(clock), .srst(srst), .link_scl(scl), .scl_i(scl), .sda_i(sda),
		.scl_o(), .scl_oe(scl_oe), .sda_o(), .sda_oe(sda_oe), .cfg(cfg), .cmd(cmd),
		.status(status));
	i2cst_master u_mst (.dev_scl_oe(scl_oe), .dev_sda_oe(sda_oe), .scl(scl), .sda(sda));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic give_verdict();
		$display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 40000)
		begin
			miscompares++;
			give_verdict();
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Kinds: 0 load, 1 own address, 2 release, 3 clear irq, 4 clear coll, 5 read
	task automatic sw(input int k, input logic [7:0] v);
		i2cst_pkg::i2cst_cmd_t c;
		c = '0;
		case (k)
			0: {c.buf_wr, c.buf_wdata} = {1'b1, v};
			1: {c.addr_wr, c.addr_wdata} = {1'b1, v};
			2: c.clock_release_set = 1'b1;
			3: c.port_irq_clr = 1'b1;
			4: c.collision_irq_clr = 1'b1;
			default: c.buf_rd = 1'b1;
		endcase
		@(negedge clock) cmd = c;
		@(negedge clock) cmd = '0;
	endtask
	task automatic wait_irq();
		int n;
		for (n = 0; n < 5000 && status.port_irq_flag !== 1'b1; n++)
			@(negedge clock);
		chk(n < 5000, 1'b1);
		repeat (3) @(negedge clock);
	endtask
	task automatic tx_byte(input logic [7:0] v);
		sw(3, 8'h00);
		txq.push_back(v);
		sw(0, v);
		chk(status.buffer_full, 1'b1);
		chk(status.transfer_buffer, v);
		sw(2, 8'h00);
		@(negedge clock);
		chk(scl_oe, 1'b0);
	endtask
	task automatic rd_chk(input logic last);
		logic [7:0] r;
		u_mst.rbyte(8'hff, last, r);
		chk(r, txq.pop_front());
	endtask

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial
	begin
		void'($urandom(99));
		fork
			u_mst.pump(8);
		join_none
		repeat (10) @(posedge clock);
		@(negedge clock);
		srst = 1'b0;
		chk({scl_oe, sda_oe, status.clock_release, status.port_irq_flag}, 8'h02);
		repeat (60) @(negedge clock);
		a7 = 7'h10 + 7'($urandom_range(0, 80));
		cfg.start_irq_enable = 1'b1;
		sw(1, {a7, 1'b0});
		fork
			begin
				u_mst.start();
				u_mst.wbyte({a7, 1'b1}, nk);
				chk(nk, 1'b0);
				rd_chk(1'b0);
				rd_chk(1'b0);
				rd_chk(1'b1);
				u_mst.stop();
			end
			begin
				wait_irq();
				chk(status.start_detected, 1'b1);
				sw(3, 8'h00);
				wait_irq();
				chk(status.read_status, 1'b1);
				chk(status.transfer_buffer, {a7, 1'b1});
				chk(scl_oe, 1'b1);
				for (int i = 0; i < 3; i++)
				begin
					chk(status.clock_release, 1'b0);
					tx_byte(8'($urandom));
					wait_irq();
					chk(status.master_ack_status, i == 2);
					chk(status.data_not_address, 1'b1);
				end
				chk(scl_oe, 1'b0);
				sw(3, 8'h00);
				chk(status.port_irq_flag, 1'b0);
			end
		join
		$display("test read7 done");
		@(negedge clock);
		cfg.start_irq_enable = 1'b0;
		u_mst.start();
		chk({status.start_detected, status.port_irq_flag}, 8'h02);
		u_mst.wbyte({a7 ^ 7'h01, 1'b1}, nk);
		chk({nk, status.port_irq_flag}, 8'h02);
		u_mst.stop();
		$display("test refuse done");
		for (int av = 0; av < 2; av++)
		begin
			@(negedge clock);
			cfg.address_hold_enable = 1'b1;
			cfg.ack_value_select = av[0];
			fork
				begin
					u_mst.start();
					u_mst.wbyte({a7, 1'b1}, nk);
					chk(nk, av[0]);
					if (av == 0)
						rd_chk(1'b1);
					u_mst.stop();
				end
				begin
					wait_irq();
					chk(status.clock_release, 1'b0);
					chk({status.ack_phase_flag, status.read_status, status.data_not_address}, 8'h06);
					sw(3, 8'h00);
					sw(2, 8'h00);
					if (av == 0)
					begin
						wait_irq();
						chk(status.clock_release, 1'b0);
						tx_byte(8'($urandom));
						wait_irq();
						sw(3, 8'h00);
					end
				end
			join
			chk(status.port_irq_flag, 1'b0);
		end
		$display("test hold done");
		@(negedge clock);
		cfg = '0;
		cfg.slave_collision_detect_enable = 1'b1;
		fork
			begin
				u_mst.start();
				u_mst.wbyte({a7, 1'b1}, nk);
				u_mst.rbyte(8'hbf, 1'b1, d);
				u_mst.stop();
			end
			begin
				wait_irq();
				tx_byte(8'hff);
			end
		join
		chk({status.collision_irq_flag, status.port_irq_flag}, 8'h02);
		sw(4, 8'h00);
		chk(status.collision_irq_flag, 1'b0);
		txq.delete();
		$display("test collision done");
		cfg = '0;
		cfg.ten_bit_mode = 1'b1;
		hi = {5'h1e, 2'($urandom), 1'b0};
		lo = 8'($urandom);
		d = 8'($urandom);
		sw(1, hi);
		for (int k = 0; k < 2; k++)
		begin
			cfg.stretch_each_byte_enable = 1'b0;
			fork
				begin
					u_mst.start();
					u_mst.wbyte(hi, nk);
					chk(nk, 1'b0);
					u_mst.wbyte(lo ^ 8'(k), nk);
					if (k == 0)
					begin
						chk(nk, 1'b0);
						u_mst.wbyte(d, nk);
						u_mst.start();
						u_mst.wbyte(hi | 8'h01, nk);
						chk(nk, 1'b0);
						rd_chk(1'b1);
					end
					u_mst.stop();
				end
				begin
					wait_irq();
					chk({status.address_update_needed, scl_oe, status.clock_release}, 8'h07);
					sw(3, 8'h00);
					sw(5, 8'h00);
					sw(1, lo);
					chk(status.own_address, lo);
					@(negedge clock);
					chk(scl_oe, 1'b0);
					wait_irq();
					chk({status.address_update_needed, status.clock_release}, 8'h03);
					chk(status.buffer_full, k == 0);
					sw(3, 8'h00);
					cfg.stretch_each_byte_enable = 1'b1;
					sw(1, hi);
					if (k == 0)
					begin
						wait_irq();
						chk(status.transfer_buffer, d);
						chk(status.clock_release, 1'b0);
						sw(3, 8'h00);
						sw(2, 8'h00);
						wait_irq();
						chk(status.read_status, 1'b1);
						tx_byte(8'($urandom));
						wait_irq();
						sw(3, 8'h00);
					end
				end
			join
		end
		$display("test tenbit done");
		give_verdict();
	end
endmodule // tb
